// ==== inc/fwsr_pkg.sv ====
package fwsr_pkg;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 20;
  // Status bit positions on the data bus
  localparam int          ACT_TOG_POS   = 6;
  localparam int          SEC_TOG_POS   = 2;
  localparam int          FAIL_POS      = 5;
  localparam int          TIMER_POS     = 3;
  localparam int          POLL_POS      = 7;
  localparam logic [7:0]  RESET_CMD     = 8'h_F0;
  // AXI4-Lite register map (byte offsets)
  localparam logic [3:0]  CTRL_OFF      = 4'h_0;
  localparam logic [3:0]  STAT_OFF      = 4'h_4;
  localparam logic [3:0]  ADDR_OFF      = 4'h_8;
  localparam logic [3:0]  DATA_OFF      = 4'h_C;
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_ABORT    = 1;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_DONE     = 1;
  localparam int          STAT_FAIL     = 2;
  localparam int          STAT_TIMER    = 3;
  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;
  // Flash strobe timing
  localparam int          CLK_MHZ       = 100;
  localparam int          T_STROBE_NS   = 80;
  localparam int          STROBE_CYC    = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int          T_SETTLE_NS   = 30;
  localparam int          SETTLE_CYC    = (T_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W         = 8;
  typedef enum logic [2:0] {
    FWSR_IDLE  = 3'b000,
    FWSR_RD    = 3'b001,
    FWSR_GAP   = 3'b010,
    FWSR_EVAL  = 3'b011,
    FWSR_WR    = 3'b100,
    FWSR_WGAP  = 3'b101
  } fwsr_state_t;
endpackage

// ==== rtl/fwsr_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
// Two-flop synchroniser for pin inputs; stage one feeds only stage two
module fwsr_sync #(
  parameter int W = 8
) (
  input  wire logic         aclk,     // Clock
  input  wire logic         aresetn,  // Sync reset, low
  input  wire logic [W-1:0] d,        // Asynchronous input
  output var  logic [W-1:0] q         // Synchronised output
);
  logic [W-1:0] meta_q;
  // Two stages, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fwsr_ctrl.sv ====
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Host-side status poller for a parallel flash running an embedded
// program or erase. Software loads an address, starts polling; the
// block runs the toggle-bit procedure and writes reset on failure.
module fwsr_ctrl (
  input  wire logic                        aclk,     // Clock 100 MHz
  input  wire logic                        aresetn,  // Sync reset, low
  input  wire logic [3:0]                  awaddr,   // AXI write address
  input  wire logic                        awvalid,  // AXI aw valid
  output var  logic                        awready,  // AXI aw ready
  input  wire logic [31:0]                 wdata,    // AXI write data
  input  wire logic [3:0]                  wstrb,    // AXI byte strobes
  input  wire logic                        wvalid,   // AXI w valid
  output var  logic                        wready,   // AXI w ready
  output var  logic [1:0]                  bresp,    // AXI write resp
  output var  logic                        bvalid,   // AXI b valid
  input  wire logic                        bready,   // AXI b ready
  input  wire logic [3:0]                  araddr,   // AXI read address
  input  wire logic                        arvalid,  // AXI ar valid
  output var  logic                        arready,  // AXI ar ready
  output var  logic [31:0]                 rdata,    // AXI read data
  output var  logic [1:0]                  rresp,    // AXI read resp
  output var  logic                        rvalid,   // AXI r valid
  input  wire logic                        rready,   // AXI r ready
  output var  logic [fwsr_pkg::ADDR_W-1:0] fl_addr,  // Flash address
  input  wire logic [fwsr_pkg::DATA_W-1:0] fl_dq_i,  // Flash data in
  output var  logic [fwsr_pkg::DATA_W-1:0] fl_dq_o,  // Flash data out
  output var  logic                        fl_dq_oe, // High: host drives
  output var  logic                        fl_ce_n,  // Chip enable, low
  output var  logic                        fl_oe_n,  // Output enable, low
  output var  logic                        fl_we_n   // Write enable, low
);
  import fwsr_pkg::*;

  fwsr_state_t              st_q;
  logic [CNT_W-1:0]         cnt_q;
  logic [ADDR_W-1:0]        addr_q;
  logic [DATA_W-1:0]        dq_s;
  logic [DATA_W-1:0]        first_q;
  logic [DATA_W-1:0]        last_q;
  logic                     have_first_q;
  logic                     rechk_q;
  logic                     busy_q;
  logic                     done_q;
  logic                     fail_q;
  logic                     timer_q;
  logic                     aw_got_q;
  logic                     w_got_q;
  logic [3:0]               waddr_q;
  logic [31:0]              wdat_q;
  logic                     start_pulse;
  logic                     abort_pulse;
  logic                     wr_fire;
  logic                     toggled;

  // Data pins come from the flash, outside our clock domain
  fwsr_sync #(.W(DATA_W)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (fl_dq_i),
    .q       (dq_s)
  );

  // Write channel capture; address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      waddr_q  <= 4'h_0;
      wdat_q   <= 32'h_0000_0000;
    end else begin
      awready <= !aw_got_q && !awready && !bvalid;
      wready  <= !w_got_q && !wready && !bvalid;
      if (awvalid && awready) begin
        aw_got_q <= 1'b1;
        waddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_q <= 1'b1;
        wdat_q  <= wdata;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
      end
    end
  end

  assign wr_fire     = aw_got_q && w_got_q && !bvalid;
  assign start_pulse = wr_fire && waddr_q == CTRL_OFF &&
                       wdat_q[CTRL_START];
  assign abort_pulse = wr_fire && waddr_q == CTRL_OFF &&
                       wdat_q[CTRL_ABORT];

  // Write response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (waddr_q == CTRL_OFF || waddr_q == ADDR_OFF)
                ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Poll address register; writes are ignored while a poll runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_q <= '0;
    end else if (wr_fire && waddr_q == ADDR_OFF && !busy_q) begin
      if (wstrb != 4'h_0) begin
        addr_q <= wdat_q[ADDR_W-1:0];
      end
    end
  end

  // Read channel; answer registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h_0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !arready && !rvalid && !arvalid ? 1'b1 :
                 (!rvalid && !(arvalid && arready));
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        case (araddr)
          CTRL_OFF: rdata <= 32'h_0000_0000;
          STAT_OFF: rdata <= {28'h_000_0000, timer_q, fail_q,
                              done_q, busy_q};
          ADDR_OFF: rdata <= {{(32-ADDR_W){1'b0}}, addr_q};
          DATA_OFF: rdata <= {{(32-DATA_W){1'b0}}, last_q};
          default: begin
            rdata <= 32'h_0000_0000;
            rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // A toggle shows as a change of bit 6 between two reads
  assign toggled = first_q[ACT_TOG_POS] != dq_s[ACT_TOG_POS];

  // Poll sequencer: read, compare, settle, maybe write reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= FWSR_IDLE;
      cnt_q        <= '0;
      first_q      <= '0;
      last_q       <= '0;
      have_first_q <= 1'b0;
      rechk_q      <= 1'b0;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      fail_q       <= 1'b0;
      timer_q      <= 1'b0;
    end else begin
      case (st_q)
        FWSR_IDLE: begin
          if (start_pulse) begin
            // Every start begins again from the first double read
            have_first_q <= 1'b0;
            rechk_q      <= 1'b0;
            busy_q       <= 1'b1;
            done_q       <= 1'b0;
            fail_q       <= 1'b0;
            cnt_q        <= CNT_W'(STROBE_CYC);
            st_q         <= FWSR_RD;
          end
        end
        FWSR_RD: begin
          if (abort_pulse) begin
            busy_q <= 1'b0;
            st_q   <= FWSR_IDLE;
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            st_q <= FWSR_EVAL;
          end
        end
        FWSR_EVAL: begin
          // Strobe is still low in this cycle; the sampled byte is in dq_s
          last_q  <= dq_s;
          timer_q <= dq_s[TIMER_POS];
          first_q <= dq_s;
          cnt_q   <= CNT_W'(SETTLE_CYC);
          st_q    <= FWSR_GAP;
          if (have_first_q) begin
            if (!toggled) begin
              busy_q <= 1'b0;
              done_q <= 1'b1;
              st_q   <= FWSR_IDLE;
            end else if (rechk_q) begin
              // Still toggling after bit 5 rose: write reset
              fail_q <= 1'b1;
              cnt_q  <= CNT_W'(STROBE_CYC);
              st_q   <= FWSR_WR;
            end else if (dq_s[FAIL_POS]) begin
              rechk_q <= 1'b1;
            end
          end
          have_first_q <= 1'b1;
        end
        FWSR_GAP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= CNT_W'(STROBE_CYC);
            st_q  <= abort_pulse ? FWSR_IDLE : FWSR_RD;
            if (abort_pulse) begin
              busy_q <= 1'b0;
            end
          end
        end
        FWSR_WR: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            cnt_q <= CNT_W'(SETTLE_CYC);
            st_q  <= FWSR_WGAP;
          end
        end
        FWSR_WGAP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end else begin
            busy_q <= 1'b0;
            st_q   <= FWSR_IDLE;
          end
        end
        default: begin
          st_q <= FWSR_IDLE;
        end
      endcase
      // Stop order ends a poll, but a failure found now still writes reset
      if (abort_pulse && (st_q == FWSR_RD || st_q == FWSR_GAP ||
          st_q == FWSR_EVAL && !(have_first_q && toggled && rechk_q))) begin
        busy_q <= 1'b0;
        st_q   <= FWSR_IDLE;
      end
    end
  end

  // Pin drive: reads pulse ce/oe, the reset command pulses ce/we
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fl_addr  <= '0;
      fl_dq_o  <= '0;
      fl_dq_oe <= 1'b0;
      fl_ce_n  <= 1'b1;
      fl_oe_n  <= 1'b1;
      fl_we_n  <= 1'b1;
    end else begin
      fl_addr  <= addr_q;
      fl_dq_o  <= RESET_CMD;
      fl_dq_oe <= st_q == FWSR_WR || st_q == FWSR_WGAP;
      fl_ce_n  <= !(st_q == FWSR_RD || st_q == FWSR_WR);
      fl_oe_n  <= !(st_q == FWSR_RD);
      fl_we_n  <= !(st_q == FWSR_WR);
    end
  end

  // Assertions
  property p_done_needs_match;
    @(posedge aclk) disable iff (!aresetn)
      $rose(done_q) |-> $past(st_q) == FWSR_EVAL &&
        $past(first_q[ACT_TOG_POS]) == $past(dq_s[ACT_TOG_POS]);
  endproperty
  a_done_needs_match: assert property (p_done_needs_match)
    else $error("done set without equal toggle reads");

  property p_fail_writes_reset;
    @(posedge aclk) disable iff (!aresetn)
      $rose(fail_q) |-> ##[1:4] (!fl_we_n && fl_dq_oe &&
        fl_dq_o == RESET_CMD);
  endproperty
  a_fail_writes_reset: assert property (p_fail_writes_reset)
    else $error("failure not followed by reset write");

  property p_fail_needs_recheck;
    @(posedge aclk) disable iff (!aresetn)
      $rose(fail_q) |-> $past(rechk_q);
  endproperty
  a_fail_needs_recheck: assert property (p_fail_needs_recheck)
    else $error("failure without prior bit 5 recheck");

  property p_restart_fresh;
    @(posedge aclk) disable iff (!aresetn)
      (st_q == FWSR_IDLE && start_pulse) |=> !have_first_q && !rechk_q;
  endproperty
  a_restart_fresh: assert property (p_restart_fresh)
    else $error("poll resumed without fresh double read");

  property p_no_drive_on_read;
    @(posedge aclk) disable iff (!aresetn)
      !fl_oe_n |-> !fl_dq_oe && fl_we_n;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read)
    else $error("bus contention during flash read");

  property p_rechk_needs_bit5;
    @(posedge aclk) disable iff (!aresetn)
      $rose(rechk_q) |-> $past(st_q) == FWSR_EVAL && $past(dq_s[FAIL_POS]);
  endproperty
  a_rechk_needs_bit5: assert property (p_rechk_needs_bit5)
    else $error("recheck started without bit 5 high");
  property p_write_is_reset;
    @(posedge aclk) disable iff (!aresetn)
      !fl_we_n |-> !fl_ce_n && fl_oe_n && fl_dq_oe && fl_dq_o == RESET_CMD;
  endproperty
  a_write_is_reset: assert property (p_write_is_reset)
    else $error("flash write is not the reset command");

  c_done: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_q));
  c_fail: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(fail_q));
  c_recheck: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(rechk_q));
endmodule
`default_nettype wire

// ==== verif/fwsr_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Behavioural flash answering reads with status while an operation runs
module fwsr_flash_model (
  input  wire logic                        ce_n,  // Chip enable, low
  input  wire logic                        oe_n,  // Output enable, low
  input  wire logic                        we_n,  // Write enable, low
  input  wire logic [fwsr_pkg::DATA_W-1:0] din,   // Byte from host
  input  wire logic                        ld,    // Starts an operation
  input  wire logic [7:0]                  n_tog, // Busy reads to give
  input  wire logic                        fail,  // Pulse limit passed
  input  wire logic                        timer, // Erase window closed
  input  wire logic [fwsr_pkg::DATA_W-1:0] arr,   // Stored byte
  output var  logic [fwsr_pkg::DATA_W-1:0] dout,  // Byte to host
  output var  logic [7:0]                  n_rst  // Reset writes seen
);
  import fwsr_pkg::*;
  int                left;
  logic              tog;
  logic [DATA_W-1:0] last;
  initial begin
    left  = 0;
    tog   = 1'b0;
    last  = '0;
    dout  = '1;
    n_rst = '0;
  end
  // A new operation restarts the toggle pattern from a known value
  always @(posedge ld) begin
    left = n_tog;
    tog  = 1'b0;
  end
  // Busy reads give status at any address; the window length stands in
  // for the short protected-sector windows as well
  always @(negedge (ce_n | oe_n)) begin
    if (we_n && left > 0) begin
      tog  = ~tog;
      left = left - 1;
      last = {1'b0, tog, fail, 1'b0, timer, tog, 2'b00};
    end else if (we_n) begin
      last = arr;
    end
    dout = last;
  end
  // Released bus shows the inverse, so a stale byte cannot pass for data
  always @(posedge (ce_n | oe_n)) dout = ~last;
  // The reset byte ends whatever runs and returns to array reads; a
  // write ends when ce or we rises, as both may rise in one step
  always @(posedge (ce_n | we_n)) begin
    if (oe_n && din === RESET_CMD) begin
      left  = 0;
      n_rst = n_rst + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fwsr_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready;
  logic rvalid, oe, ce_n, oe_n, we_n, ld = 0, fl = 0, tm = 0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v;
  logic [1:0] bresp, rresp, r;
  logic [19:0] fl_addr, ad;
  logic [7:0] dq_o, mdq, dq_i, arr = '0, ntog = '0, n_rst, rc, dx;
  logic fx;
  int fails = 0, n_compared = 0, i, k, seed;
  assign dq_i = oe ? dq_o : mdq;
  always #5 aclk = ~aclk;
  fwsr_ctrl fwsr_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'h_F), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .fl_addr(fl_addr), .fl_dq_i(dq_i), .fl_dq_o(dq_o),
    .fl_dq_oe(oe), .fl_ce_n(ce_n), .fl_oe_n(oe_n), .fl_we_n(we_n));
  fwsr_flash_model fwsr_flash_model_inst (.ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .din(dq_i), .ld(ld), .n_tog(ntog), .fail(fl),
    .timer(tm), .arr(arr), .dout(mdq), .n_rst(n_rst));
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tb) begin bready <= 0; return; end
    end
    fails++; wrap_up();
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d,
                     output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = arvalid & arready; tr = rvalid; d = rdata; rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 0;
      if (tr) begin rready <= 0; return; end
    end
    fails++; wrap_up();
  endtask
  // Runs the toggle procedure over the bytes the model will give:
  // n status bytes, then the stored byte from there on
  function automatic void predict(input int n, input logic [7:0] a,
                                  output logic f, output logic [7:0] d);
    logic [7:0] b, p;
    logic tg, rk, fin;
    tg = 0; rk = 0; fin = 0; f = 0; p = a; d = a;
    for (int j = 0; j < n + 3; j++) begin
      b = a;
      if (j < n) begin tg = ~tg; b = {1'b0, tg, fl, 1'b0, tm, tg, 2'b00}; end
      if (!fin && j > 0) begin
        d = b; fin = (b[6] === p[6]) || rk; f = rk && !(b[6] === p[6]);
        rk = rk | b[5];
      end
      p = b;
    end
  endfunction
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    seed = $urandom(72);
    axr(STAT_OFF, v, r); chk(v, 32'h_0000_0000);
    axr(CTRL_OFF, v, r); chk(v, 32'h_0000_0000);
    axr(4'h_2, v, r); chk(r, RESP_SLVERR);
    axw(4'h_6, 32'h_0000_0001, r); chk(r, RESP_SLVERR);
    // First two runs stop just as bit 5 rises: one success, one failure
    for (i = 0; i < 12; i++) begin
      ad = 20'($urandom); arr = 8'($urandom); tm = 1'($urandom);
      fl = (i < 2) | 1'($urandom); rc = n_rst;
      case (i < 2 ? 1 : $urandom % 4)
        0: ntog <= 8'h_00;
        1: ntog <= 8'h_02;
        2: ntog <= 8'h_05;
        default: begin ntog <= 8'h_C8; fl = 1; end
      endcase
      if (i < 2) arr[6] = i[0];
      axw(ADDR_OFF, {12'h_000, ad}, r); chk(r, RESP_OKAY);
      axr(ADDR_OFF, v, r); chk(v[19:0], ad);
      ld <= 1; @(posedge aclk); ld <= 0;
      predict(ntog, arr, fx, dx);
      axw(CTRL_OFF, 32'h_0000_0001, r); chk(r, RESP_OKAY);
      for (k = 0; k < 300; k++) begin
        axr(STAT_OFF, v, r);
        if (v[STAT_BUSY] === 1'b0) break;
      end
      if (k == 300) begin fails++; wrap_up(); end
      chk(v, {28'h0, dx[3], fx, !fx, 1'b0});
      axr(DATA_OFF, v, r); chk(v, {24'h0, dx});
      chk(fl_addr, ad);
      chk(n_rst, rc + fx);
    end
    // Stop order in mid-poll: no verdict, no reset write, oe strobe idle
    ntog <= 8'h_C8; fl = 0; rc = n_rst;
    ld <= 1; @(posedge aclk); ld <= 0;
    axw(CTRL_OFF, 32'h_0000_0001, r); chk(r, RESP_OKAY);
    repeat (40) @(posedge aclk);
    axw(CTRL_OFF, 32'h_0000_0002, r); chk(r, RESP_OKAY);
    axr(STAT_OFF, v, r); chk(v[2:0], 3'b000);
    chk(n_rst, rc);
    chk(oe_n, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
